// ==== hw/acr_pkg.sv ====
// Shared constants and types for the amplifier configuration register bank.
// Assumes an I2C slave front end with byte offsets 0x00 to 0x03.
package acr_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CHAN_CFG = 8'h00;
  localparam logic [7:0] OFF_MISC1 = 8'h01;
  localparam logic [7:0] OFF_MISC2 = 8'h02;
  localparam logic [7:0] OFF_SAP_FMT = 8'h03;
  // Reset values
  localparam logic [7:0] CHAN_CFG_RST = 8'h00;
  localparam logic [7:0] MISC1_RST = 8'h32;
  localparam logic [7:0] MISC2_RST = 8'h62;
  localparam logic [7:0] SAP_FMT_RST = 8'h04;
  // Reserved bits 7 and 3 of the second misc register read as zero
  localparam logic [7:0] MISC2_WMASK = 8'h77;
  // Field positions
  localparam int RST_BIT = 7;
  localparam int PAIR_UP_BIT = 5;
  localparam int PAIR_LO_BIT = 4;
  localparam int LINE_LSB = 0;
  localparam int HPF_BIT = 7;
  localparam int OTW_LSB = 5;
  localparam int OC_BIT = 4;
  localparam int RAMP_LSB = 2;
  localparam int GAIN_LSB = 0;
  localparam int FREQ_LSB = 4;
  localparam int OSR_BIT = 2;
  localparam int PHASE_LSB = 0;
  localparam int RATE_LSB = 6;
  localparam int HALF_BIT = 5;
  localparam int SIZE_BIT = 4;
  localparam int SWAP_BIT = 3;
  localparam int FMT_LSB = 0;
  // Codes checked for validity, then the bit count of a byte
  localparam logic [2:0] FREQ_RSVD_LO = 3'h2;
  localparam logic [2:0] FREQ_RSVD_HI = 3'h4;
  localparam logic [2:0] FREQ_48X = 3'h7;
  localparam logic [1:0] RATE_48K = 2'h1;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [2:0] FMT_RSVD = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_TXNEXT} acr_fsm_e;
  typedef enum logic [1:0] {PH_DEV, PH_SUB, PH_DATA} acr_phase_e;

  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    logic fsS1;
    logic fsS2;
    logic fsD;
    acr_fsm_e fsm;
    acr_phase_e phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rdMode;
    logic sdaOe;
    logic sdaOutBit;
    logic [3:0][7:0] regs;
    logic rstPulse;
    logic [2:0] rampCnt;
    logic stepStrobe;
    logic cfgErr;
  } acr_state_s;
endpackage

// ==== hw/acr_config_regs.sv ====
// Configuration register bank of a four-channel amplifier, reached over I2C.
// Assumes SCL, SDA and the frame sync come from pins outside this clock domain.
//
// Notes on behaviour
// - Writing one to channel config bit 7 resets the device; zero is normal.
// - Channel config bit 5 pairs channels 3 and 4 into one bridge.
// - Channel config bit 4 pairs channels 1 and 2 into one bridge.
// - Channel config bits 3..0 put channels 1..4 into line output mode.
// - Misc one bit 7 set bypasses the input high-pass filter.
// - Misc one bits 6..5 pick overtemperature warning, 140 down to 110 C.
// - Misc one bit 4 picks overcurrent level 1 or 2, reset level 2.
// - Misc one bits 3..2 give one volume step per 1, 2, 4, 8 frame syncs.
// - Misc one bits 1..0 pick one of four gains, reset code 10.
// - Misc two bits 6..4 set switching frequency; 010-100 reserved.
// - Misc two bit 2 picks modulator oversampling 64x or 128x.
// - Misc two bits 1..0 set output phase offset, reset code 10.
// - Format bits 7..6 declare 44.1, 48 or 96 kHz; 11 reserved.
// - Format bit 5 picks first or last four slots of eight.
// - Format bit 4 picks 24/32-bit or 16-bit TDM slots.
// - Format bit 3 swaps channel 1/2 slots with channel 3/4 slots.
// - Format bits 2..0 pick input format; 111 reserved.
// - Registers reached over I2C; address increments after each written byte and each acknowledged read byte.
`timescale 1ns/1ns
module acr_config_regs
  import acr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary default slave address
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // I2C pins, SDA open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Audio frame sync pin
  input wire logic frameSyncIn,
  // Output stage configuration
  output logic deviceResetPulse,
  output logic pairUpperBridges,
  output logic pairLowerBridges,
  output logic [3:0] lineOutSelect,
  // Protection and gain
  output logic highpassSkip,
  output logic [1:0] overtempWarnThreshold,
  output logic overcurrentLevelSelect,
  output logic [1:0] volumeRampRate,
  output logic [1:0] gainLevel,
  output logic volumeStepStrobe,
  // Modulator
  output logic [2:0] switchFreqSelect,
  output logic modulatorOversampling,
  output logic [1:0] outputPhaseOffset,
  // Serial audio port
  output logic [1:0] sampleRateSelect,
  output logic eightSlotHalfSelect,
  output logic tdmSlotNarrow,
  output logic channelPairSwap,
  output logic [2:0] inputFormat,
  output logic configCodeInvalid
);

  localparam logic [1:0] IDX_CHAN = OFF_CHAN_CFG[1:0];
  localparam logic [1:0] IDX_MISC1 = OFF_MISC1[1:0];
  localparam logic [1:0] IDX_MISC2 = OFF_MISC2[1:0];
  localparam logic [1:0] IDX_SAP = OFF_SAP_FMT[1:0];
  localparam logic [3:0][7:0] REG_DEFAULTS = {SAP_FMT_RST, MISC2_RST, MISC1_RST, CHAN_CFG_RST};

  // Reserved general-call and ten-bit address groups cannot be served
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_addr_check
    $error("DEV_ADDR lies in a reserved I2C address group");
  end

  acr_state_s s;
  acr_state_s n;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic fsRise;
  logic wrEn;
  logic [1:0] wrIdx;
  logic [7:0] wrData;

  // Unmapped offsets read as zero
  function automatic logic [7:0] regRead(input logic [3:0][7:0] r, input logic [7:0] a);
    regRead = (a <= OFF_SAP_FMT) ? r[a[1:0]] : 8'h00;
  endfunction

  // Bits that a write may change
  function automatic logic [7:0] writeMask(input logic [1:0] idx);
    writeMask = (idx == IDX_MISC2) ? MISC2_WMASK : 8'hFF;
  endfunction

  // Edges are taken from the second synchroniser stage only
  assign sclRise = s.sclS2 & ~s.sclD;
  assign sclFall = ~s.sclS2 & s.sclD;
  assign startSeen = s.sclS2 & s.sclD & s.sdaD & ~s.sdaS2;
  assign stopSeen = s.sclS2 & s.sclD & ~s.sdaD & s.sdaS2;
  assign fsRise = s.fsS2 & ~s.fsD;

  // Next state of the whole block
  always_comb begin
    n = s;
    wrEn = 1'b0;
    wrIdx = s.ptr[1:0];
    wrData = s.shift;
    n.sclS1 = sclIn;
    n.sclS2 = s.sclS1;
    n.sclD = s.sclS2;
    n.sdaS1 = sdaIn;
    n.sdaS2 = s.sdaS1;
    n.sdaD = s.sdaS2;
    n.fsS1 = frameSyncIn;
    n.fsS2 = s.fsS1;
    n.fsD = s.fsS2;
    n.rstPulse = 1'b0;
    n.stepStrobe = 1'b0;
    n.sdaOutBit = 1'b0;
    // Volume step pacing; >= recovers when the rate shrinks mid count
    if (fsRise) begin
      if (s.rampCnt >= 3'((4'h1 << s.regs[IDX_MISC1][RAMP_LSB +: 2]) - 4'h1)) begin
        n.rampCnt = 3'h0;
        n.stepStrobe = 1'b1;
      end else begin
        n.rampCnt = s.rampCnt + 3'h1;
      end
    end
    case (s.fsm)
      ST_IDLE: begin
        n.sdaOe = 1'b0;
      end
      ST_RX: begin
        if (sclRise) begin
          n.shift = {s.shift[6:0], s.sdaS2};
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (sclFall && s.bitCnt == BYTE_BITS) begin
          n.bitCnt = 4'h0;
          n.fsm = ST_ACK;
          n.sdaOe = 1'b1;
          case (s.phase)
            PH_DEV: begin
              n.rdMode = s.shift[0];
              n.phase = PH_SUB;
              // Foreign address: stay silent until the next start
              if (s.shift[7:1] != DEV_ADDR) begin
                n.fsm = ST_IDLE;
                n.sdaOe = 1'b0;
              end
            end
            PH_SUB: begin
              n.ptr = s.shift;
              n.phase = PH_DATA;
            end
            default: begin
              n.ptr = s.ptr + 8'h01;
              wrEn = (s.ptr <= OFF_SAP_FMT);
            end
          endcase
        end
      end
      ST_ACK: begin
        if (sclFall) begin
          if (s.rdMode) begin
            n.shift = regRead(s.regs, s.ptr);
            n.sdaOe = ~n.shift[7];
            n.fsm = ST_TX;
          end else begin
            n.sdaOe = 1'b0;
            n.fsm = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (sclRise) begin
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (sclFall) begin
          if (s.bitCnt == BYTE_BITS) begin
            n.sdaOe = 1'b0;
            n.bitCnt = 4'h0;
            n.fsm = ST_TXACK;
          end else begin
            n.shift = {s.shift[6:0], 1'b0};
            n.sdaOe = ~s.shift[6];
          end
        end
      end
      ST_TXACK: begin
        if (sclRise) begin
          if (s.sdaS2) begin
            n.fsm = ST_IDLE;
          end else begin
            n.ptr = s.ptr + 8'h01;
            n.fsm = ST_TXNEXT;
          end
        end
      end
      ST_TXNEXT: begin
        if (sclFall) begin
          n.shift = regRead(s.regs, s.ptr);
          n.sdaOe = ~n.shift[7];
          n.fsm = ST_TX;
        end
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase
    // Register update; self reset also restarts the step pacing
    if (wrEn) begin
      if (wrIdx == IDX_CHAN && wrData[RST_BIT]) begin
        n.regs = REG_DEFAULTS;
        n.rstPulse = 1'b1;
        n.rampCnt = 3'h0;
      end else begin
        n.regs[wrIdx] = wrData & writeMask(wrIdx);
      end
    end
    // Start and stop override any byte in flight
    if (startSeen) begin
      n.fsm = ST_RX;
      n.phase = PH_DEV;
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0;
    end else if (stopSeen) begin
      n.fsm = ST_IDLE;
      n.sdaOe = 1'b0;
    end
    // Reserved or unsupported code combinations
    n.cfgErr = (n.regs[IDX_SAP][RATE_LSB +: 2] == RATE_RSVD)
      || (n.regs[IDX_SAP][FMT_LSB +: 3] == FMT_RSVD)
      || (n.regs[IDX_MISC2][FREQ_LSB +: 3] >= FREQ_RSVD_LO && n.regs[IDX_MISC2][FREQ_LSB +: 3] <= FREQ_RSVD_HI)
      || (n.regs[IDX_MISC2][FREQ_LSB +: 3] == FREQ_48X && n.regs[IDX_SAP][RATE_LSB +: 2] == RATE_48K);
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.regs <= REG_DEFAULTS;
      // Bus lines idle high, so the edge detectors start there and see no false edge
      s.sclS1 <= 1'b1;
      s.sclS2 <= 1'b1;
      s.sclD <= 1'b1;
      s.sdaS1 <= 1'b1;
      s.sdaS2 <= 1'b1;
      s.sdaD <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // I2C pin drive and self reset pulse
  assign sdaOut = s.sdaOutBit;
  assign sdaOe = s.sdaOe;
  assign deviceResetPulse = s.rstPulse;
  // Channel configuration fields
  assign pairUpperBridges = s.regs[IDX_CHAN][PAIR_UP_BIT];
  assign pairLowerBridges = s.regs[IDX_CHAN][PAIR_LO_BIT];
  assign lineOutSelect = s.regs[IDX_CHAN][LINE_LSB +: 4];
  // First misc register fields
  assign highpassSkip = s.regs[IDX_MISC1][HPF_BIT];
  assign overtempWarnThreshold = s.regs[IDX_MISC1][OTW_LSB +: 2];
  assign overcurrentLevelSelect = s.regs[IDX_MISC1][OC_BIT];
  assign volumeRampRate = s.regs[IDX_MISC1][RAMP_LSB +: 2];
  assign gainLevel = s.regs[IDX_MISC1][GAIN_LSB +: 2];
  assign volumeStepStrobe = s.stepStrobe;
  // Second misc register fields
  assign switchFreqSelect = s.regs[IDX_MISC2][FREQ_LSB +: 3];
  assign modulatorOversampling = s.regs[IDX_MISC2][OSR_BIT];
  assign outputPhaseOffset = s.regs[IDX_MISC2][PHASE_LSB +: 2];
  // Serial audio format fields
  assign sampleRateSelect = s.regs[IDX_SAP][RATE_LSB +: 2];
  assign eightSlotHalfSelect = s.regs[IDX_SAP][HALF_BIT];
  assign tdmSlotNarrow = s.regs[IDX_SAP][SIZE_BIT];
  assign channelPairSwap = s.regs[IDX_SAP][SWAP_BIT];
  assign inputFormat = s.regs[IDX_SAP][FMT_LSB +: 3];
  assign configCodeInvalid = s.cfgErr;

  // Checks on register behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_soft_clear;
    wrEn && wrIdx == IDX_CHAN && wrData[RST_BIT] |=> s.regs == REG_DEFAULTS && !s.regs[IDX_CHAN][RST_BIT];
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("self reset left a register off default");

  property p_reset_pulse;
    wrEn && wrIdx == IDX_CHAN && wrData[RST_BIT] |=> deviceResetPulse ##1 !deviceResetPulse;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not exactly one cycle");

  property p_ptr_inc;
    wrEn |=> s.ptr == $past(s.ptr) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("address did not advance after a data byte");

  property p_pair_up;
    wrEn && wrIdx == IDX_CHAN && !wrData[RST_BIT] |=> pairUpperBridges == $past(wrData[PAIR_UP_BIT]);
  endproperty
  a_pair_up: assert property (p_pair_up) else $error("upper pairing not taken from write");

  property p_pair_lo;
    wrEn && wrIdx == IDX_CHAN && !wrData[RST_BIT] |=> pairLowerBridges == $past(wrData[PAIR_LO_BIT]);
  endproperty
  a_pair_lo: assert property (p_pair_lo) else $error("lower pairing not taken from write");

  property p_line_out;
    wrEn && wrIdx == IDX_CHAN && !wrData[RST_BIT] |=> lineOutSelect == $past(wrData[3:0]);
  endproperty
  a_line_out: assert property (p_line_out) else $error("line output select wrong");

  property p_misc1;
    wrEn && wrIdx == IDX_MISC1 |=> {highpassSkip, overtempWarnThreshold, overcurrentLevelSelect,
      volumeRampRate, gainLevel} == $past(wrData);
  endproperty
  a_misc1: assert property (p_misc1) else $error("first misc fields wrong after write");

  property p_misc2;
    wrEn && wrIdx == IDX_MISC2 |=> {1'b0, switchFreqSelect, 1'b0, modulatorOversampling,
      outputPhaseOffset} == ($past(wrData) & MISC2_WMASK);
  endproperty
  a_misc2: assert property (p_misc2) else $error("second misc fields wrong after write");

  property p_sap;
    wrEn && wrIdx == IDX_SAP |=> {sampleRateSelect, eightSlotHalfSelect, tdmSlotNarrow,
      channelPairSwap, inputFormat} == $past(wrData);
  endproperty
  a_sap: assert property (p_sap) else $error("format fields wrong after write");

  property p_ramp_fast;
    fsRise && volumeRampRate == 2'h0 && !wrEn |=> volumeStepStrobe;
  endproperty
  a_ramp_fast: assert property (p_ramp_fast) else $error("no step on a frame sync at rate one");

  property p_rate_rsvd;
    sampleRateSelect == RATE_RSVD |-> configCodeInvalid;
  endproperty
  a_rate_rsvd: assert property (p_rate_rsvd) else $error("reserved rate not flagged");

  c_write: cover property (wrEn && wrIdx == IDX_MISC1);
  c_read: cover property (s.fsm == ST_TX ##[1:1000] s.fsm == ST_TXACK);
  c_soft: cover property (deviceResetPulse);
  c_step: cover property (volumeStepStrobe && volumeRampRate == 2'h3);
endmodule

// ==== dv/acr_i2c_host.sv ====
// I2C host model that configures the amplifier register bank.
// Assumes SDA is resolved outside with a pull-up and fed back on sdaLine.
`timescale 1ns/1ns
module acr_i2c_host (
  // Clock
  input wire logic ref_clk,
  // Bus pins
  output logic sclOut,
  output logic sdaLow,
  input wire logic sdaLine,
  // Received byte report, one-cycle strobe
  output logic rdStrobe,
  output logic [7:0] rdData
);
  localparam int HALF = 8;

  // Idle bus: both lines released
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    rdStrobe = 1'b0;
    rdData = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // SDA moves two clocks after SCL fall so the slave sees a clean hold
  task automatic bitXfer(input logic bOut, output logic bIn);
    sdaLow = ~bOut;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    bIn = sdaLine;
    sclOut = 1'b0;
    tick(2);
  endtask

  // Start or repeated start, leaves SCL low
  task automatic start();
    sdaLow = 1'b0;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    sdaLow = 1'b1;
    tick(HALF);
    sclOut = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    sdaLow = 1'b0;
    tick(2 * HALF);
  endtask

  // Sends a byte; acked is high when the slave pulled the ninth bit low
  task automatic sendByte(input logic [7:0] d, output logic acked);
    logic b;
    for (int i = 7; i >= 0; i--) bitXfer(d[i], b);
    bitXfer(1'b1, b);
    acked = ~b;
  endtask

  // Receives a byte; the last one is not acknowledged
  task automatic getByte(input logic last);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(1'b1, b);
      rdData[i] = b;
    end
    bitXfer(last, b);
    rdStrobe = 1'b1;
    tick(1);
    rdStrobe = 1'b0;
  endtask

  // Offset once, then data bytes that land at consecutive offsets
  task automatic writeRegs(input logic [6:0] dev, input logic [7:0] off, input logic [3:0][7:0] d, input int n,
                           output logic acked);
    logic a;
    start();
    sendByte({dev, 1'b0}, acked);
    sendByte(off, a);
    acked &= a;
    for (int i = 0; i < n; i++) begin
      sendByte(d[i], a);
      acked &= a;
    end
    stop();
  endtask

  task automatic readRegs(input logic [6:0] dev, input logic [7:0] off, input int n);
    logic a;
    start();
    sendByte({dev, 1'b0}, a);
    sendByte(off, a);
    start();
    sendByte({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) getByte(i == n - 1);
    stop();
  endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the amplifier configuration register bank.
// Assumes the I2C host model drives the bus and SDA has a pull-up.
`timescale 1ns/1ns
module tb
  import acr_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary slave address
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic frameSyncIn = 1'b0;
  logic sclLine, hostLow, sdaLine, sdaOut, sdaOe, acked;
  logic deviceResetPulse, pairUpperBridges, pairLowerBridges, highpassSkip, overcurrentLevelSelect;
  logic volumeStepStrobe, modulatorOversampling, eightSlotHalfSelect, tdmSlotNarrow, channelPairSwap;
  logic configCodeInvalid;
  logic [3:0] lineOutSelect;
  logic [1:0] overtempWarnThreshold, volumeRampRate, gainLevel, outputPhaseOffset, sampleRateSelect;
  logic [2:0] switchFreqSelect, inputFormat;
  logic [2:0] freqTab [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  logic [1:0] rateTab [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] expQ [$];
  logic [15:0] rnd = 16'h987F;
  logic [3:0][7:0] cur;
  int err_total = 0;
  int n_checks = 0;
  int nRstPulse = 0;
  int nStep = 0;
  int rstSeen, stepSeen;

  always #5 ref_clk = ~ref_clk;
  // Open-drain wire with pull-up
  assign sdaLine = ~(hostLow | (sdaOe & ~sdaOut));

  acr_i2c_host u_host (.ref_clk(ref_clk), .sclOut(sclLine), .sdaLow(hostLow), .sdaLine(sdaLine),
    .rdStrobe(), .rdData());
  acr_config_regs #(.DEV_ADDR(DEV)) u_dut (.ref_clk(ref_clk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .frameSyncIn(frameSyncIn), .deviceResetPulse(deviceResetPulse),
    .pairUpperBridges(pairUpperBridges), .pairLowerBridges(pairLowerBridges), .lineOutSelect(lineOutSelect),
    .highpassSkip(highpassSkip), .overtempWarnThreshold(overtempWarnThreshold),
    .overcurrentLevelSelect(overcurrentLevelSelect), .volumeRampRate(volumeRampRate), .gainLevel(gainLevel),
    .volumeStepStrobe(volumeStepStrobe), .switchFreqSelect(switchFreqSelect),
    .modulatorOversampling(modulatorOversampling), .outputPhaseOffset(outputPhaseOffset),
    .sampleRateSelect(sampleRateSelect), .eightSlotHalfSelect(eightSlotHalfSelect),
    .tdmSlotNarrow(tdmSlotNarrow), .channelPairSwap(channelPairSwap), .inputFormat(inputFormat),
    .configCodeInvalid(configCodeInvalid));

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read monitor: each received byte is matched with the oldest note
  always @(posedge ref_clk) begin
    if (u_host.rdStrobe === 1'b1) begin
      if (expQ.size() > 0) check(u_host.rdData, expQ.pop_front());
      else check(u_host.rdData, ~u_host.rdData);
    end
    if (deviceResetPulse === 1'b1) nRstPulse++;
    if (volumeStepStrobe === 1'b1) nStep++;
  end

  // Bounded wait until the monitor has used up every note
  task automatic drain();
    int k = 0;
    while (expQ.size() > 0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (expQ.size() > 0) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] off, input logic [3:0][7:0] d, input int n);
    u_host.writeRegs(DEV, off, d, n, acked);
    check({7'h00, acked}, 8'h01);
  endtask

  // Field outputs first, then a sequential read of the whole bank
  task automatic verify(input logic [3:0][7:0] e);
    logic bad;
    // Reserved rate or format, reserved frequency, or 48x at 48 kHz
    bad = e[3][7:6] == RATE_RSVD || e[3][2:0] == FMT_RSVD || (e[2][6:4] >= FREQ_RSVD_LO && e[2][6:4] <= FREQ_RSVD_HI)
      || (e[2][6:4] == FREQ_48X && e[3][7:6] == RATE_48K);
    check({7'h00, configCodeInvalid}, {7'h00, bad});
    check({2'b00, pairUpperBridges, pairLowerBridges, lineOutSelect}, {2'b00, e[0][5:0]});
    check({highpassSkip, overtempWarnThreshold, overcurrentLevelSelect, volumeRampRate, gainLevel}, e[1]);
    check({1'b0, switchFreqSelect, 1'b0, modulatorOversampling, outputPhaseOffset}, e[2]);
    check({sampleRateSelect, eightSlotHalfSelect, tdmSlotNarrow, channelPairSwap, inputFormat}, e[3]);
    for (int i = 0; i < 4; i++) expQ.push_back(e[i]);
    u_host.readRegs(DEV, OFF_CHAN_CFG, 4);
    drain();
  endtask

  initial begin
    tick(20);
    rst = 1'b0;
    tick(6);
    verify({SAP_FMT_RST, MISC2_RST, MISC1_RST, CHAN_CFG_RST});
    $display("test reset_values done");
    // Every documented code of each enumerated field, random elsewhere
    for (int i = 0; i < 7; i++) begin
      rnd = lfsrNext(rnd);
      cur[0] = {1'b0, rnd[6:0]};
      cur[1] = {rnd[7], i[1:0], rnd[4], i[1:0], i[1:0]};
      cur[2] = {1'b0, freqTab[i % 5], 1'b0, rnd[8], i[1:0]};
      cur[3] = {rateTab[i % 3], rnd[11:9], i[2:0]};
      wr(OFF_CHAN_CFG, cur, 4);
      verify(cur);
    end
    $display("test code_sweep done");
    // Reserved bits read zero, reserved codes are flagged, a byte past the bank is dropped
    wr(OFF_MISC2, {8'h00, 8'hAA, 8'hC7, 8'hFF}, 3);
    expQ = '{8'h77, 8'hC7, 8'h00};
    u_host.readRegs(DEV, OFF_MISC2, 3);
    drain();
    check({7'h00, configCodeInvalid}, 8'h01);
    // Another slave address is not acknowledged and changes nothing
    u_host.writeRegs(DEV ^ 7'h01, OFF_CHAN_CFG, {24'h0, 8'h3F}, 1, acked);
    check({7'h00, acked}, 8'h00);
    expQ.push_back(cur[0]);
    u_host.readRegs(DEV, OFF_CHAN_CFG, 1);
    drain();
    $display("test refusals done");
    // Self reset clears the step counter, so each ramp rate starts from zero
    for (int r = 0; r < 4; r++) begin
      rstSeen = nRstPulse;
      wr(OFF_CHAN_CFG, {24'h0, 8'h80 | cur[0]}, 1);
      check(8'(nRstPulse - rstSeen), 8'h01);
      if (r == 0) verify({SAP_FMT_RST, MISC2_RST, MISC1_RST, CHAN_CFG_RST});
      wr(OFF_MISC1, {24'h0, 4'h3, r[1:0], 2'h2}, 1);
      stepSeen = nStep;
      repeat (16) begin
        frameSyncIn = 1'b1;
        tick(4);
        frameSyncIn = 1'b0;
        tick(4);
      end
      tick(8);
      check(8'(nStep - stepSeen), 8'(16 >> r));
    end
    $display("test self_reset_ramp done");
    close_out();
  end

  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule
